// ---- rtl/bdma_pkg.sv ----
// Constants and types shared by the banked data memory addressing block
package bdma_pkg;

    // Data space geometry
    localparam int          ADDR_W         = 12;
    localparam int          BANK_COUNT     = 16;
    localparam int          BANK_BYTES     = 256;
    localparam int          SCRATCH_BYTES  = 512;
    localparam logic [11:0] SCRATCH_BASE   = 12'h000;
    localparam logic [11:0] SCRATCH_LIMIT  = 12'h200;

    // Fixed access window split and bases
    localparam logic [7:0]  WIN_SPLIT      = 8'h60;
    localparam logic [11:0] WIN_LOW_BASE   = 12'h000;
    localparam logic [11:0] WIN_HIGH_BASE  = 12'hF00;

    // Core registers inside the peripheral control space
    localparam logic [11:0] ADDR_BANK_PTR  = 12'hFE0;
    localparam logic [11:0] ADDR_FLAGS     = 12'hFD8;

    // Bank pointer layout and reset
    localparam int          BANK_LSB       = 0;
    localparam int          BANK_W         = 4;
    localparam logic [3:0]  BANK_RESET     = 4'h0;

    // Flag register layout and reset
    localparam int          FLAG_CARRY     = 0;
    localparam int          FLAG_HALF      = 1;
    localparam int          FLAG_ZERO      = 2;
    localparam int          FLAG_WRAP      = 3;
    localparam int          FLAG_SIGN      = 4;
    localparam int          FLAGS_W        = 5;
    localparam logic [4:0]  FLAGS_RESET    = 5'h00;

    // Flags touched by each class of operation
    localparam logic [4:0]  MASK_ARITH     = 5'h1F;
    localparam logic [4:0]  MASK_CLEAR     = 5'h04;
    localparam logic [4:0]  MASK_MOVE      = 5'h14;
    localparam logic [4:0]  MASK_NONE      = 5'h00;

    // Operation kinds presented by the execute stage
    typedef enum logic [3:0] {
        BDMA_OP_NONE       = 4'h0,
        BDMA_OP_LOAD_BANK  = 4'h1,
        BDMA_OP_FULL_MOVE  = 4'h3,
        BDMA_OP_ADD        = 4'h2,
        BDMA_OP_SUB        = 4'h6,
        BDMA_OP_CLEAR      = 4'h7,
        BDMA_OP_BIT_SET    = 4'h5,
        BDMA_OP_BIT_CLEAR  = 4'h4,
        BDMA_OP_SWAP       = 4'hC,
        BDMA_OP_WORK_MOVE  = 4'hD,
        BDMA_OP_READ       = 4'hF
    } bdma_op_t;

endpackage

// ---- rtl/bdma_addr_resolve.sv ----
// Combinational data address resolver for direct and pointer accesses
`timescale 1ns/1ns
module bdma_addr_resolve (
    // Operand selection
    input  wire logic [7:0]  offset,
    input  wire logic        window_sel,
    input  wire logic        indirect,
    input  wire logic [11:0] pointer,
    // Context
    input  wire logic [3:0]  bank,
    input  wire logic        ext_enable,
    input  wire logic [11:0] frame_base,
    // Result
    output logic      [11:0] addr
);

    // Resolved in the same cycle, so a fresh bank value serves the next instruction
    always_comb begin
        if (indirect) begin
            addr = pointer;
        end else if (window_sel) begin
            addr = {bank, offset};
        end else if (offset < bdma_pkg::WIN_SPLIT) begin
            if (ext_enable) begin
                addr = 12'(frame_base + {4'h0, offset});
            end else begin
                addr = bdma_pkg::WIN_LOW_BASE + {4'h0, offset};
            end
        end else begin
            addr = bdma_pkg::WIN_HIGH_BASE + {4'h0, offset};
        end
    end

endmodule

// ---- rtl/bdma_core.sv ----
// Banked data memory: bank pointer, address forming, scratch RAM and flag register
`timescale 1ns/1ns
module bdma_core (
    // Clock and reset
    input  wire logic                     REF_CLK,
    input  wire logic                     RESETN,
    // Configuration strap
    input  wire logic                     EXT_SET_ENABLE,
    input  wire logic [11:0]              FRAME_BASE,
    // Instruction request
    input  wire logic                     OP_VALID,
    input  wire bdma_pkg::bdma_op_t       OP_KIND,
    input  wire logic [7:0]               OP_OFFSET,
    input  wire logic                     OP_WINDOW_SEL,
    input  wire logic                     OP_INDIRECT,
    input  wire logic [11:0]              OP_POINTER,
    input  wire logic                     OP_DEST_FILE,
    input  wire logic [7:0]               OP_LITERAL,
    input  wire logic [2:0]               OP_BIT_SEL,
    input  wire logic [7:0]               OP_WORK,
    input  wire logic [11:0]              OP_FULL_SRC,
    input  wire logic [11:0]              OP_FULL_DST,
    // Results
    output logic      [7:0]               RD_DATA,
    output logic      [7:0]               W_DATA,
    output logic                          W_LOAD,
    output logic      [11:0]              EFF_ADDR,
    output logic      [7:0]               BANK_POINTER,
    output logic      [4:0]               FLAGS
);

    // Whole block state; the scratch array is left out of the reset branch
    typedef struct packed {
        logic [bdma_pkg::SCRATCH_BYTES-1:0][7:0] ram;
        logic [3:0]                              bank;
        logic [4:0]                              flags;
        logic [7:0]                              rd_data;
        logic [7:0]                              w_data;
        logic                                    w_load;
        logic [11:0]                             eff_addr;
        logic                                    ext_s1;
        logic                                    ext_s2;
    } bdma_state_t;

    bdma_state_t st_reg;
    bdma_state_t st_next;
    logic [11:0] res_addr;

    // Decode of the scratch RAM range; used by both read and write paths
    function automatic logic is_scratch(input logic [11:0] a);
        return (a < bdma_pkg::SCRATCH_LIMIT);
    endfunction

    // Places that answer inside the 12-bit data space
    typedef enum logic [1:0] {
        BDMA_TGT_NONE    = 2'b00,
        BDMA_TGT_SCRATCH = 2'b01,
        BDMA_TGT_BANK    = 2'b11,
        BDMA_TGT_FLAGS   = 2'b10
    } bdma_tgt_t;

    // One map for reads and writes, so no location reads back what it refuses
    function automatic bdma_tgt_t space_target(input logic [11:0] a);
        bdma_tgt_t t;
        t = BDMA_TGT_NONE;
        if (is_scratch(a)) begin
            t = BDMA_TGT_SCRATCH;
        end else if (a == bdma_pkg::ADDR_BANK_PTR) begin
            t = BDMA_TGT_BANK;
        end else if (a == bdma_pkg::ADDR_FLAGS) begin
            t = BDMA_TGT_FLAGS;
        end
        return t;
    endfunction

    // One-hot bit select shared by bit set and bit clear
    function automatic logic [7:0] bit_mask(input logic [2:0] n);
        return 8'h01 << n;
    endfunction

    // Read view of the data space; unmapped addresses return zero
    function automatic logic [7:0] space_read(input bdma_state_t s, input logic [11:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (space_target(a))
            BDMA_TGT_SCRATCH: begin
                v = s.ram[a[8:0]];
            end
            BDMA_TGT_BANK: begin
                v = {4'h0, s.bank};
            end
            BDMA_TGT_FLAGS: begin
                v = {3'h0, s.flags};
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // Operand address from bank pointer, fixed window or pointer
    bdma_addr_resolve u_resolve (
        .offset     (OP_OFFSET),
        .window_sel (OP_WINDOW_SEL),
        .indirect   (OP_INDIRECT),
        .pointer    (OP_POINTER),
        .bank       (st_reg.bank),
        .ext_enable (st_reg.ext_s2),
        .frame_base (FRAME_BASE),
        .addr       (res_addr)
    );

    // Next-state logic: one instruction is executed per clock
    always_comb begin
        // Working values of the current instruction
        logic [7:0]  opnd;
        logic [7:0]  res;
        logic [7:0]  b_in;
        logic [8:0]  sum9;
        logic [4:0]  half5;
        logic [4:0]  calc;
        logic [4:0]  mask;
        logic [4:0]  merged;
        logic        wr_en;
        logic [11:0] wr_addr;
        logic [7:0]  wr_val;
        logic        is_sub;
        // Defaults keep every path assigned
        opnd    = 8'h00;
        res     = 8'h00;
        b_in    = 8'h00;
        sum9    = 9'h000;
        half5   = 5'h00;
        calc    = 5'h00;
        mask    = bdma_pkg::MASK_NONE;
        merged  = 5'h00;
        wr_en   = 1'b0;
        wr_addr = 12'h000;
        wr_val  = 8'h00;
        is_sub  = 1'b0;
        st_next = st_reg;
        // Strap is asynchronous to the core, so it is synchronised first
        st_next.ext_s1 = EXT_SET_ENABLE;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.w_load = 1'b0;
        // Synchronous reset; the scratch array keeps whatever it held
        if (!RESETN) begin
            st_next.bank     = bdma_pkg::BANK_RESET;
            st_next.flags    = bdma_pkg::FLAGS_RESET;
            st_next.rd_data  = 8'h00;
            st_next.w_data   = 8'h00;
            st_next.eff_addr = 12'h000;
            st_next.ext_s1   = 1'b0;
            st_next.ext_s2   = 1'b0;
        end else if (OP_VALID) begin
            opnd = space_read(st_reg, res_addr);
            st_next.eff_addr = res_addr;
            // Result, target and flag mask of each kind
            case (OP_KIND)
                bdma_pkg::BDMA_OP_LOAD_BANK: begin
                    // Literal straight into the pointer; the operand is still read, but nothing is written back
                    st_next.bank = OP_LITERAL[3:0];
                end
                bdma_pkg::BDMA_OP_FULL_MOVE: begin
                    // Both addresses come whole from the opcode
                    opnd = space_read(st_reg, OP_FULL_SRC);
                    res = opnd;
                    wr_en = 1'b1;
                    wr_addr = OP_FULL_DST;
                    st_next.eff_addr = OP_FULL_DST;
                end
                bdma_pkg::BDMA_OP_ADD,
                bdma_pkg::BDMA_OP_SUB: begin
                    // Subtract is f + ~W + 1, so carry outs read as not-borrow
                    is_sub = (OP_KIND == bdma_pkg::BDMA_OP_SUB);
                    b_in = is_sub ? ~OP_WORK : OP_WORK;
                    sum9 = {1'b0, opnd} + {1'b0, b_in} + {8'h00, is_sub};
                    half5 = {1'b0, opnd[3:0]} + {1'b0, b_in[3:0]} + {4'h0, is_sub};
                    res = sum9[7:0];
                    calc[bdma_pkg::FLAG_CARRY] = sum9[8];
                    calc[bdma_pkg::FLAG_HALF] = half5[4];
                    calc[bdma_pkg::FLAG_WRAP] = (opnd[7] == b_in[7]) && (res[7] != opnd[7]);
                    mask = bdma_pkg::MASK_ARITH;
                    wr_en = OP_DEST_FILE;
                    wr_addr = res_addr;
                end
                bdma_pkg::BDMA_OP_CLEAR: begin
                    // Clear writes zero and raises only the zero flag
                    res = 8'h00;
                    mask = bdma_pkg::MASK_CLEAR;
                    wr_en = 1'b1;
                    wr_addr = res_addr;
                end
                bdma_pkg::BDMA_OP_BIT_SET: begin
                    // Read, set one bit, write back
                    res = opnd | bit_mask(OP_BIT_SEL);
                    wr_en = 1'b1;
                    wr_addr = res_addr;
                end
                bdma_pkg::BDMA_OP_BIT_CLEAR: begin
                    // Read, clear one bit, write back
                    res = opnd & ~bit_mask(OP_BIT_SEL);
                    wr_en = 1'b1;
                    wr_addr = res_addr;
                end
                bdma_pkg::BDMA_OP_SWAP: begin
                    // Nibbles exchanged; flags untouched
                    res = {opnd[3:0], opnd[7:4]};
                    wr_en = OP_DEST_FILE;
                    wr_addr = res_addr;
                end
                bdma_pkg::BDMA_OP_WORK_MOVE: begin
                    // Working register to file; flags untouched
                    res = OP_WORK;
                    wr_en = 1'b1;
                    wr_addr = res_addr;
                end
                bdma_pkg::BDMA_OP_READ: begin
                    // Plain move updates zero and sign only
                    res = opnd;
                    mask = bdma_pkg::MASK_MOVE;
                    wr_en = OP_DEST_FILE;
                    wr_addr = res_addr;
                end
                default: begin
                    // No-op still reports its operand and address
                    res = opnd;
                end
            endcase
            // Zero and sign follow the result byte of every op
            calc[bdma_pkg::FLAG_ZERO] = (res == 8'h00);
            calc[bdma_pkg::FLAG_SIGN] = res[7];
            // Only the bits in the op's mask may move
            merged = (st_reg.flags & ~mask) | (calc & mask);
            // Operand as read, shown to the execute stage
            st_next.rd_data = opnd;
            // Result to the working register when the file is not the target, except for load-bank and no-op
            if ((OP_KIND != bdma_pkg::BDMA_OP_LOAD_BANK) && (OP_KIND != bdma_pkg::BDMA_OP_NONE) && !wr_en) begin
                st_next.w_data = res;
                st_next.w_load = 1'b1;
            end
            // Flag update does not depend on whether the target exists
            if (mask != bdma_pkg::MASK_NONE) begin
                st_next.flags = merged;
            end
            wr_val = res;
            // Write-back through the same map as the operand read
            if (wr_en) begin
                case (space_target(wr_addr))
                    BDMA_TGT_SCRATCH: begin
                        st_next.ram[wr_addr[8:0]] = wr_val;
                    end
                    BDMA_TGT_BANK: begin
                        st_next.bank = wr_val[3:0];
                    end
                    BDMA_TGT_FLAGS: begin
                        // A flag-setting op keeps its merged flags; its result is dropped
                        if (mask == bdma_pkg::MASK_NONE) begin
                            st_next.flags = wr_val[4:0];
                        end
                    end
                    default: begin
                        // Unimplemented target: the write is lost
                    end
                endcase
            end
        end
    end

    // Single state register; reset is synchronous and spares the scratch array
    always_ff @(posedge REF_CLK) begin
        st_reg <= st_next;
    end

    // Outputs straight from state flip-flops
    assign RD_DATA      = st_reg.rd_data;
    assign W_DATA       = st_reg.w_data;
    assign W_LOAD       = st_reg.w_load;
    assign EFF_ADDR     = st_reg.eff_addr;
    assign BANK_POINTER = {4'h0, st_reg.bank};
    assign FLAGS        = st_reg.flags;

endmodule

// ---- dv/bdma_core_monitor.sv ----
// Concurrent checks on the ports of the banked data memory core
`timescale 1ns/1ns
module bdma_core_monitor (
    // Clock, reset and strap
    input wire logic               REF_CLK,
    input wire logic               RESETN,
    input wire logic               EXT_SET_ENABLE,
    input wire logic [11:0]        FRAME_BASE,
    // Instruction request
    input wire logic               OP_VALID,
    input wire bdma_pkg::bdma_op_t OP_KIND,
    input wire logic [7:0]         OP_OFFSET,
    input wire logic               OP_WINDOW_SEL,
    input wire logic               OP_INDIRECT,
    input wire logic [11:0]        OP_POINTER,
    input wire logic [7:0]         OP_LITERAL,
    input wire logic [11:0]        OP_FULL_DST,
    // Results
    input wire logic [11:0]        EFF_ADDR,
    input wire logic [7:0]         BANK_POINTER,
    input wire logic [4:0]         FLAGS
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    // Operation classes; load-bank and full move carry no offset address
    wire logic is_fm = OP_VALID && OP_KIND == bdma_pkg::BDMA_OP_FULL_MOVE;
    wire logic is_lb = OP_VALID && OP_KIND == bdma_pkg::BDMA_OP_LOAD_BANK;
    wire logic ptr_op = OP_VALID && OP_INDIRECT && !is_fm && !is_lb;
    wire logic dir_op = OP_VALID && !OP_INDIRECT && !is_fm && !is_lb;
    wire logic win_lo = dir_op && !OP_WINDOW_SEL && OP_OFFSET < 8'h60;

    property p_upper_zero; BANK_POINTER[7:4] == 4'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("bank pointer upper nibble set");
    property p_load; is_lb |=> BANK_POINTER == {4'h0, $past(OP_LITERAL[3:0])}; endproperty
    a_load: assert property (p_load) else $error("bank load wrong");
    property p_banked; dir_op && OP_WINDOW_SEL |=> EFF_ADDR == {$past(BANK_POINTER[3:0]), $past(OP_OFFSET)}; endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");
    // Strap goes through two flops, so look two edges back and across no reset
    property p_win_low;
        win_lo && !EXT_SET_ENABLE && !$past(EXT_SET_ENABLE) && !$past(EXT_SET_ENABLE, 2)
        |=> EFF_ADDR == {4'h0, $past(OP_OFFSET)};
    endproperty
    a_win_low: assert property (p_win_low) else $error("low window address wrong");
    property p_win_ext;
        win_lo && EXT_SET_ENABLE && $past(EXT_SET_ENABLE) && $past(EXT_SET_ENABLE, 2) && $past(RESETN)
        && $past(RESETN, 2) |=> EFF_ADDR == $past(FRAME_BASE) + {4'h0, $past(OP_OFFSET)};
    endproperty
    a_win_ext: assert property (p_win_ext) else $error("alternative window wrong");
    property p_win_high;
        dir_op && !OP_WINDOW_SEL && OP_OFFSET >= 8'h60 |=> EFF_ADDR == {4'hF, $past(OP_OFFSET)};
    endproperty
    a_win_high: assert property (p_win_high) else $error("high window address wrong");
    property p_ptr; ptr_op |=> EFF_ADDR == $past(OP_POINTER); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer address wrong");
    property p_full; is_fm |=> EFF_ADDR == $past(OP_FULL_DST); endproperty
    a_full: assert property (p_full) else $error("full move address wrong");
    property p_keep;
        OP_VALID && OP_KIND inside {bdma_pkg::BDMA_OP_BIT_SET, bdma_pkg::BDMA_OP_BIT_CLEAR, bdma_pkg::BDMA_OP_SWAP,
        bdma_pkg::BDMA_OP_FULL_MOVE, bdma_pkg::BDMA_OP_WORK_MOVE} |=> EFF_ADDR == bdma_pkg::ADDR_FLAGS || $stable(FLAGS);
    endproperty
    a_keep: assert property (p_keep) else $error("flags moved by neutral op");
    property p_clear; OP_VALID && OP_KIND == bdma_pkg::BDMA_OP_CLEAR |=> FLAGS == ($past(FLAGS) | 5'h04); endproperty
    a_clear: assert property (p_clear) else $error("clear flags wrong");

    // Main scenarios reached
    c_load: cover property (is_lb ##1 dir_op && OP_WINDOW_SEL);
    c_ext: cover property (win_lo && EXT_SET_ENABLE);
    c_ptr: cover property (ptr_op);
endmodule

bind bdma_core bdma_core_monitor u_bdma_core_monitor (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .EXT_SET_ENABLE(EXT_SET_ENABLE), .FRAME_BASE(FRAME_BASE), .OP_VALID(OP_VALID), .OP_KIND(OP_KIND),
    .OP_OFFSET(OP_OFFSET), .OP_WINDOW_SEL(OP_WINDOW_SEL), .OP_INDIRECT(OP_INDIRECT), .OP_POINTER(OP_POINTER),
    .OP_LITERAL(OP_LITERAL), .OP_FULL_DST(OP_FULL_DST), .EFF_ADDR(EFF_ADDR), .BANK_POINTER(BANK_POINTER),
    .FLAGS(FLAGS));

// ---- dv/bdma_cpu_model.sv ----
// Execute-stage stand-in that hands the core one operation per cycle
`timescale 1ns/1ns
module bdma_cpu_model (
    // Clock
    input  wire logic         ref_clk,
    // Operation fields
    output logic               op_valid,
    output bdma_pkg::bdma_op_t op_kind,
    output logic [7:0]         op_offset,
    output logic               op_window_sel,
    output logic               op_indirect,
    output logic [11:0]        op_pointer,
    output logic [7:0]         op_data,
    output logic [11:0]        op_addr2
);
    // Idle fields at time zero
    initial begin
        op_valid = 1'b0;
        op_kind = bdma_pkg::BDMA_OP_NONE;
        op_offset = 8'h00;
        op_window_sel = 1'b0;
        op_indirect = 1'b0;
        op_pointer = 12'h000;
        op_data = 8'h00;
        op_addr2 = 12'h000;
    end

    // Drive at the falling edge, hold across the taking edge; back to back allowed
    task automatic issue(input bdma_pkg::bdma_op_t k, input logic [11:0] a, input logic ws, input logic [7:0] d,
                         input logic ind, input logic [11:0] a2);
        op_kind = k;
        op_offset = a[7:0];
        op_pointer = a;
        op_window_sel = ws;
        op_data = d;
        op_indirect = ind;
        op_addr2 = a2;
        op_valid = 1'b1;
        @(negedge ref_clk);
    endtask

    // Offset, data and pointer flip so stale values never look valid
    task automatic idle;
        op_valid = 1'b0;
        op_offset = ~op_offset;
        op_data = ~op_data;
        op_pointer = ~op_pointer;
        @(negedge ref_clk);
    endtask
endmodule

// ---- dv/tb_banked_data_memory_addressing.sv ----
// Self-checking bench for the banked data memory core
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb_banked_data_memory_addressing;
    logic               ref_clk = 1'b0;
    logic               resetn = 1'b0;
    logic               ext_en = 1'b0;
    logic [11:0]        frame_base = 12'h000;
    logic               op_valid;
    bdma_pkg::bdma_op_t op_kind;
    logic [7:0]         op_offset;
    logic               op_window_sel;
    logic               op_indirect;
    logic [11:0]        op_pointer;
    logic [7:0]         op_data;
    logic [11:0]        op_addr2;
    logic [7:0]         rd_data;
    logic [11:0]        eff_addr;
    logic [7:0]         bank_ptr;
    logic [4:0]         flags;
    logic               w_load;
    logic [7:0]         w_data;
    logic               op_dest = 1'b0;
    int                 fail_count = 0;
    int                 checks_done = 0;

    // Clock at 100 ns
    always #50 ref_clk = ~ref_clk;

    bdma_core u_bdma_core (.REF_CLK(ref_clk), .RESETN(resetn), .EXT_SET_ENABLE(ext_en), .FRAME_BASE(frame_base),
        .OP_VALID(op_valid), .OP_KIND(op_kind), .OP_OFFSET(op_offset), .OP_WINDOW_SEL(op_window_sel),
        .OP_INDIRECT(op_indirect), .OP_POINTER(op_pointer), .OP_DEST_FILE(op_dest), .OP_LITERAL(op_data),
        .OP_BIT_SEL(op_data[2:0]), .OP_WORK(op_data), .OP_FULL_SRC(op_pointer), .OP_FULL_DST(op_addr2),
        .RD_DATA(rd_data), .W_DATA(w_data), .W_LOAD(w_load), .EFF_ADDR(eff_addr), .BANK_POINTER(bank_ptr),
        .FLAGS(flags));
    bdma_cpu_model u_bdma_cpu_model (.ref_clk(ref_clk), .op_valid(op_valid), .op_kind(op_kind),
        .op_offset(op_offset), .op_window_sel(op_window_sel), .op_indirect(op_indirect), .op_pointer(op_pointer),
        .op_data(op_data), .op_addr2(op_addr2));

    task automatic op(input bdma_pkg::bdma_op_t k, input logic [11:0] a, input logic ws, input logic [7:0] d,
                      input logic ind = 1'b0, input logic [11:0] a2 = 12'h000);
        u_bdma_cpu_model.issue(k, a, ws, d, ind, a2);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bank load, then a banked write and read on the very next cycles
    task automatic t_bank;
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 12'h000, 1'b0, 8'hA5);
        `CHK(bank_ptr, 8'h05)
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 12'h000, 1'b0, 8'h01);
        op(bdma_pkg::BDMA_OP_WORK_MOVE, 12'h010, 1'b1, 8'hAA);
        `CHK(eff_addr, 12'h110)
        op(bdma_pkg::BDMA_OP_READ, 12'h010, 1'b1, 8'h00);
        `CHK(rd_data, 8'hAA)
        `CHK(w_data, 8'hAA)
        `CHK(w_load, 1'b1)
        $display("bank test done");
    endtask

    // Unimplemented bank drops writes, reads zero, flags still move
    task automatic t_unimpl;
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 12'h000, 1'b0, 8'h03);
        op(bdma_pkg::BDMA_OP_WORK_MOVE, 12'h020, 1'b1, 8'h55);
        `CHK(eff_addr, 12'h320)
        op(bdma_pkg::BDMA_OP_READ, 12'h020, 1'b1, 8'h00);
        `CHK(rd_data, 8'h00)
        op(bdma_pkg::BDMA_OP_ADD, 12'h020, 1'b1, 8'h80);
        `CHK(flags, 5'h10)
        $display("unimplemented bank test done");
    endtask

    // Fixed window ignores the bank pointer; top gaps read zero
    task automatic t_window;
        op(bdma_pkg::BDMA_OP_WORK_MOVE, 12'h030, 1'b0, 8'h3C);
        `CHK(eff_addr, 12'h030)
        op(bdma_pkg::BDMA_OP_READ, 12'h0E0, 1'b0, 8'h00);
        `CHK(rd_data, 8'h03)
        op(bdma_pkg::BDMA_OP_READ, 12'h030, 1'b1, 8'h00);
        `CHK(rd_data, 8'h00)
        op(bdma_pkg::BDMA_OP_READ, 12'h0D0, 1'b0, 8'h00);
        `CHK(rd_data, 8'h00)
        $display("window test done");
    endtask

    // Borrow sense of subtraction, flag register as destination
    task automatic t_flags;
        op(bdma_pkg::BDMA_OP_WORK_MOVE, 12'h000, 1'b0, 8'h05);
        op(bdma_pkg::BDMA_OP_SUB, 12'h000, 1'b0, 8'h05);
        `CHK(flags, 5'h07)
        op(bdma_pkg::BDMA_OP_SUB, 12'h000, 1'b0, 8'h06);
        `CHK(flags, 5'h10)
        op(bdma_pkg::BDMA_OP_CLEAR, 12'h0D8, 1'b0, 8'h00);
        `CHK(flags, 5'h14)
        op(bdma_pkg::BDMA_OP_BIT_SET, 12'h0D8, 1'b0, 8'h00);
        `CHK(flags, 5'h15)
        $display("flag test done");
    endtask

    // Full move and pointer access both bypass bank and window
    task automatic t_move;
        op(bdma_pkg::BDMA_OP_FULL_MOVE, 12'h030, 1'b1, 8'h00, 1'b0, 12'h1F0);
        `CHK(eff_addr, 12'h1F0)
        `CHK(flags, 5'h15)
        op(bdma_pkg::BDMA_OP_READ, 12'h1F0, 1'b1, 8'h00, 1'b1);
        `CHK(rd_data, 8'h3C)
        $display("full move test done");
    endtask

    // Results back to the file, flag register as target, result to the working register
    task automatic t_dest;
        op_dest = 1'b1;
        op(bdma_pkg::BDMA_OP_WORK_MOVE, 12'h040, 1'b0, 8'h9F);
        op(bdma_pkg::BDMA_OP_SWAP, 12'h040, 1'b0, 8'h00);
        `CHK(w_load, 1'b0)
        op(bdma_pkg::BDMA_OP_BIT_CLEAR, 12'h040, 1'b0, 8'h07);
        `CHK(flags, 5'h01)
        op(bdma_pkg::BDMA_OP_READ, 12'h040, 1'b0, 8'h00);
        `CHK(rd_data, 8'h79)
        op(bdma_pkg::BDMA_OP_ADD, 12'h0D8, 1'b0, 8'h01);
        `CHK(flags, 5'h00)
        op_dest = 1'b0;
        op(bdma_pkg::BDMA_OP_SUB, 12'h040, 1'b0, 8'h80);
        `CHK(w_data, 8'hF9)
        `CHK(flags, 5'h1A)
        op(bdma_pkg::BDMA_OP_NONE, 12'h040, 1'b0, 8'h00);
        `CHK(rd_data, 8'h79)
        `CHK(w_load, 1'b0)
        $display("destination test done");
    endtask

    // Alternative window, then a reset that must keep scratch contents
    task automatic t_ext_reset;
        frame_base = 12'h100;
        ext_en = 1'b1;
        repeat (3) u_bdma_cpu_model.idle();
        `CHK(w_load, 1'b0)
        op(bdma_pkg::BDMA_OP_READ, 12'h010, 1'b0, 8'h00);
        `CHK(eff_addr, 12'h110)
        ext_en = 1'b0;
        u_bdma_cpu_model.idle();
        resetn = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(bank_ptr, 8'h00)
        `CHK(flags, 5'h00)
        resetn = 1'b1;
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 12'h000, 1'b0, 8'h01);
        op(bdma_pkg::BDMA_OP_READ, 12'h010, 1'b1, 8'h00);
        `CHK(rd_data, 8'hAA)
        $display("reset test done");
    endtask

    // Hang guard
    initial begin
        repeat (3000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end

    // Main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        t_bank();
        t_unimpl();
        t_window();
        t_flags();
        t_move();
        t_dest();
        t_ext_reset();
        stop_test();
    end
endmodule
